/* hw/dac_ctrl_params.svh */
// Constants for the stereo DAC digital control core.
// Assumes inclusion by the core only.
// Operation
// - Output mux routes stereo, left, right or average
// - De-emphasis bit enables de-emphasis filter
// - Zero flag after 1024 or 2048 zeros
// - Tri-level pin picks two-wire, four-wire, pins
// - Pin mode: format pins and de-emphasis pin
// - Pin mode: mute pin low soft-ramps down
// - Flag after mute done; release steps back; in pin mode the code restores full gain at once
// - Pin mode flag: zeros, muted, or off
// - Clocks plus mute high: off to enabled
// - Clocks, mute low: standby; stays without bit clock
// - Standby to enabled on mute high, bit clock
// - Mute low or no bit clock: ramp to standby
// - Master clock stop powers fully off
// - Offset zero reads identity; write resets all
// - Revision register returns three-bit revision only
// - Power field selects state; auto sequencing
// - Format field and word length field decode
// - Frame clock invert, or DSP mode A/B
// - Bit clock invert: edge or output polarity
// - Master select and bit clock divider codes
// - Clock ratio field: auto or fixed ratios
// - Zero-cross enable bit for step changes
// - Clock stop keeps registers; restart resequences
// - Soft ramp rate scales with sample rate
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH
`define ADDR_ID 8'h00
`define ADDR_REV 8'h01
`define ADDR_PWR 8'h02
`define ADDR_FMT 8'h03
`define ADDR_CLK 8'h04
`define ADDR_MUTE 8'h05
`define ADDR_GAINL 8'h06
`define ADDR_GAINR 8'h07
`define ADDR_ZERO 8'h08
`define RST_PWR 16'h0000
`define RST_FMT 16'h1812
`define RST_CLK 16'h0000
`define RST_MUTE 16'h0001
`define RST_GAIN 16'h0190
`define RST_ZERO 16'h0000
`define MASK_PWR 16'h0003
`define MASK_FMT 16'h01FB
`define MASK_CLK 16'h00FF
`define MASK_MUTE 16'h001F
`define MASK_GAIN 16'h01FF
`define MASK_ZERO 16'h0001
`define BIT_COMMIT 9
`define DIV_MAX_CODE 3'h4
`define ZERO_RUN_SHORT 12'h400
`define ZERO_RUN_LONG 12'h800
`define GAIN_FULL 9'h100
`endif

/* hw/dac_ctrl_pkg.sv */
// Types shared by the stereo DAC digital control core.
// Assumes the constants header sits beside it.
package dac_ctrl_pkg;
    // Power sequencer states
    typedef enum logic [1:0] {PWR_OFF, PWR_STANDBY, PWR_MUTED, PWR_PLAY} power_state_t;
    // Control method picked by the tri-level pin
    typedef enum logic [1:0] {CTRL_TWO_WIRE, CTRL_FOUR_WIRE, CTRL_PINS} control_mode_t;
    // Pin inputs, all from outside the clock domain
    typedef struct packed {
        logic mclk_running;
        logic bclk_running;
        logic mute_pin_n;
        logic deemphasis_pin;
        logic format_pin_high;
        logic format_pin_low;
        logic cif_high;
        logic cif_floating;
    } pins_t;
    // One stereo sample with its strobe
    typedef struct packed {
        logic valid;
        logic [23:0] left;
        logic [23:0] right;
    } sample_t;
    // Effective audio interface setup for the serial port
    typedef struct packed {
        logic [1:0] format_field;
        logic [1:0] word_length_field;
        logic frame_clock_invert;
        logic bit_clock_invert;
        logic clock_master_select;
        logic [2:0] bit_clock_divider;
        logic [2:0] clock_ratio_field;
        logic zero_cross_enable;
        logic gain_rise_ramp_enable;
        logic gain_fall_ramp_enable;
    } aif_cfg_t;
endpackage : dac_ctrl_pkg

/* hw/stereo_dac_digital_control.sv */
// Register bank, power sequencer, mixing, de-emphasis, mute and zero detect.
// Assumes the serial receiver and control decoder share mclk.
`timescale 1ns/1ps
`include "dac_ctrl_params.svh"
module stereo_dac_digital_control #(
    parameter logic [15:0] DEVICE_ID = 16'h5A3C, // Arbitrary identity value
    parameter logic [2:0] SILICON_REV = 3'h0 // Arbitrary revision value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register access from the control interface decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Hardware pins
    input wire dac_ctrl_pkg::pins_t pins,
    // Audio stream
    input wire dac_ctrl_pkg::sample_t in_sample,
    output dac_ctrl_pkg::sample_t out_sample,
    // Status and setup
    output logic zero_flag_out,
    output dac_ctrl_pkg::power_state_t power_state,
    output dac_ctrl_pkg::control_mode_t control_mode,
    output dac_ctrl_pkg::aif_cfg_t aif_cfg,
    output logic [8:0] left_gain_active,
    output logic [8:0] right_gain_active
);
    import dac_ctrl_pkg::*;

    // Register storage
    logic [15:0] pwr_reg;
    logic [15:0] fmt_reg;
    logic [15:0] clk_reg;
    logic [15:0] mute_reg;
    logic [15:0] gainl_reg;
    logic [15:0] gainr_reg;
    logic [15:0] zero_reg;
    // Synchronised pins
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    pins_t pin;
    // Sequencer and ramp state
    power_state_t state_reg;
    power_state_t state_next;
    logic [8:0] ramp_reg [2];
    logic [1:0] mute_req;
    logic ramps_done;
    logic hw_mode;
    // Zero run counter
    logic [11:0] zero_cnt_reg;
    logic zero_seen;
    logic [11:0] zero_limit;
    logic both_zero;
    // Mixed samples
    logic [23:0] mix_l;
    logic [23:0] mix_r;
    logic [24:0] mix_sum;
    logic deemphasis_pin_on;

    assign pin = pins_t'(pin_sync_reg);
    assign hw_mode = (control_mode == CTRL_PINS);

    // Two-stage synchroniser per pin
    genvar gp;
    generate
        for (gp = 0; gp < 8; gp++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (reset) begin
                    pin_meta_reg[gp] <= 1'b0;
                    pin_sync_reg[gp] <= 1'b0;
                end else begin
                    pin_meta_reg[gp] <= pins[gp];
                    pin_sync_reg[gp] <= pin_meta_reg[gp];
                end
            end
        end
    endgenerate

    // Control method from the tri-level pin
    always_comb begin
        if (pin.cif_floating) begin
            control_mode = CTRL_PINS;
        end else if (pin.cif_high) begin
            control_mode = CTRL_FOUR_WIRE;
        end else begin
            control_mode = CTRL_TWO_WIRE;
        end
    end

    // Register writes; a write to offset zero restores defaults
    always_ff @(posedge mclk) begin
        if (reset || (reg_wr && reg_addr == `ADDR_ID)) begin
            pwr_reg <= `RST_PWR & `MASK_PWR;
            fmt_reg <= `RST_FMT & `MASK_FMT;
            clk_reg <= `RST_CLK & `MASK_CLK;
            mute_reg <= `RST_MUTE & `MASK_MUTE;
            gainl_reg <= `RST_GAIN & `MASK_GAIN;
            gainr_reg <= `RST_GAIN & `MASK_GAIN;
            zero_reg <= `RST_ZERO & `MASK_ZERO;
        end else if (reg_wr) begin
            // Reserved bits are dropped so they read zero
            case (reg_addr)
                `ADDR_PWR: pwr_reg <= reg_wdata & `MASK_PWR;
                `ADDR_FMT: fmt_reg <= reg_wdata & `MASK_FMT;
                `ADDR_CLK: begin
                    // Reserved divider codes keep the old divider
                    clk_reg[7:6] <= reg_wdata[7:6];
                    clk_reg[2:0] <= reg_wdata[2:0];
                    if (reg_wdata[5:3] <= `DIV_MAX_CODE) begin
                        clk_reg[5:3] <= reg_wdata[5:3];
                    end
                end
                `ADDR_MUTE: mute_reg <= reg_wdata & `MASK_MUTE;
                `ADDR_GAINL: gainl_reg <= reg_wdata & `MASK_GAIN;
                `ADDR_GAINR: gainr_reg <= reg_wdata & `MASK_GAIN;
                `ADDR_ZERO: zero_reg <= reg_wdata & `MASK_ZERO;
                default: ; // Unlisted offsets ignored
            endcase
        end
    end

    // Gain commit: either commit bit updates both channels together
    always_ff @(posedge mclk) begin
        if (reset || (reg_wr && reg_addr == `ADDR_ID)) begin
            left_gain_active <= 9'(`RST_GAIN);
            right_gain_active <= 9'(`RST_GAIN);
        end else if (reg_wr && reg_wdata[`BIT_COMMIT]) begin
            if (reg_addr == `ADDR_GAINL) begin
                left_gain_active <= reg_wdata[8:0];
                right_gain_active <= gainr_reg[8:0];
            end else if (reg_addr == `ADDR_GAINR) begin
                left_gain_active <= gainl_reg[8:0];
                right_gain_active <= reg_wdata[8:0];
            end
        end
    end

    // Register reads, registered with a one-cycle valid
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_ID: reg_rdata <= DEVICE_ID;
                    `ADDR_REV: reg_rdata <= {13'h0000, SILICON_REV};
                    `ADDR_PWR: reg_rdata <= pwr_reg;
                    `ADDR_FMT: reg_rdata <= fmt_reg;
                    `ADDR_CLK: reg_rdata <= clk_reg;
                    `ADDR_MUTE: reg_rdata <= mute_reg;
                    `ADDR_GAINL: reg_rdata <= gainl_reg;
                    `ADDR_GAINR: reg_rdata <= gainr_reg;
                    `ADDR_ZERO: reg_rdata <= zero_reg;
                    default: reg_rdata <= 16'h0000; // Unmapped reads zero
                endcase
            end
        end
    end

    // Effective interface setup; pins override format in pin mode
    always_comb begin
        aif_cfg.format_field = fmt_reg[1:0];
        aif_cfg.word_length_field = fmt_reg[4:3];
        aif_cfg.bit_clock_invert = fmt_reg[5];
        aif_cfg.frame_clock_invert = fmt_reg[6];
        aif_cfg.clock_master_select = fmt_reg[7];
        aif_cfg.bit_clock_divider = clk_reg[5:3];
        aif_cfg.clock_ratio_field = clk_reg[2:0];
        aif_cfg.zero_cross_enable = mute_reg[4];
        aif_cfg.gain_rise_ramp_enable = mute_reg[1];
        aif_cfg.gain_fall_ramp_enable = mute_reg[0];
        deemphasis_pin_on = fmt_reg[8];
        if (hw_mode) begin
            // Pins: 00 LJ24, 01 I2S24, 10 RJ16, 11 RJ24
            case ({pin.format_pin_high, pin.format_pin_low})
                2'b00: aif_cfg.format_field = 2'h1;
                2'b01: aif_cfg.format_field = 2'h2;
                default: aif_cfg.format_field = 2'h0;
            endcase
            aif_cfg.word_length_field = ({pin.format_pin_high, pin.format_pin_low} == 2'b10)
                ? 2'h0 : 2'h2;
            aif_cfg.bit_clock_invert = 1'b0;
            aif_cfg.frame_clock_invert = 1'b0;
            aif_cfg.clock_master_select = 1'b0;
            aif_cfg.clock_ratio_field = 3'h0;
            aif_cfg.zero_cross_enable = 1'b0;
            aif_cfg.gain_rise_ramp_enable = 1'b0;
            aif_cfg.gain_fall_ramp_enable = 1'b1;
            deemphasis_pin_on = pin.deemphasis_pin;
        end
    end

    // Power sequencer next state; clock loss and pin-mode power-up can skip stages
    always_comb begin
        state_next = state_reg;
        if (!pin.mclk_running) begin
            state_next = PWR_OFF;
        end else if (hw_mode) begin
            case (state_reg)
                PWR_OFF: begin
                    if (pin.bclk_running) begin
                        state_next = pin.mute_pin_n ? PWR_MUTED : PWR_STANDBY;
                    end
                end
                PWR_STANDBY: begin
                    if (pin.mute_pin_n && pin.bclk_running) begin
                        state_next = PWR_MUTED;
                    end
                end
                PWR_MUTED: begin
                    if (pin.mute_pin_n && pin.bclk_running) begin
                        state_next = PWR_PLAY;
                    end else if (ramps_done) begin
                        state_next = PWR_STANDBY;
                    end
                end
                PWR_PLAY: begin
                    if (!pin.mute_pin_n || !pin.bclk_running) begin
                        state_next = PWR_MUTED;
                    end
                end
                default: state_next = PWR_OFF;
            endcase
        end else begin
            // Walk toward the power field, muting before stepping down
            case (state_reg)
                PWR_OFF: begin
                    if (pwr_reg[1:0] != 2'h0) begin
                        state_next = PWR_STANDBY;
                    end
                end
                PWR_STANDBY: begin
                    if (pwr_reg[1]) begin
                        state_next = PWR_MUTED;
                    end else if (pwr_reg[1:0] == 2'h0) begin
                        state_next = PWR_OFF;
                    end
                end
                PWR_MUTED: begin
                    if (pwr_reg[1:0] == 2'h3) begin
                        state_next = PWR_PLAY;
                    end else if (!pwr_reg[1] && ramps_done) begin
                        state_next = PWR_STANDBY;
                    end
                end
                PWR_PLAY: begin
                    if (pwr_reg[1:0] != 2'h3) begin
                        state_next = PWR_MUTED;
                    end
                end
                default: state_next = PWR_OFF;
            endcase
        end
    end

    // Power sequencer state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= PWR_OFF;
        end else begin
            state_reg <= state_next;
        end
    end
    assign power_state = state_reg;

    // Mixer: stereo, left to both, right to both, or average
    always_comb begin
        mix_sum = {in_sample.left[23], in_sample.left} + {in_sample.right[23], in_sample.right};
        case (clk_reg[7:6])
            2'b01: begin
                mix_l = in_sample.left;
                mix_r = in_sample.left;
            end
            2'b10: begin
                mix_l = in_sample.right;
                mix_r = in_sample.right;
            end
            2'b11: begin
                mix_l = mix_sum[24:1];
                mix_r = mix_sum[24:1];
            end
            default: begin
                mix_l = in_sample.left;
                mix_r = in_sample.right;
            end
        endcase
    end

    // Per-channel soft mute ramp, de-emphasis and gain stage
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_chan
            logic [23:0] x_in;
            logic [23:0] x_prev_reg;
            logic [23:0] y_prev_reg;
            logic [25:0] y_wide;
            logic [23:0] y_filt;
            logic [33:0] prod;
            logic ch_mute;
            logic rise_ramp;
            logic fall_ramp;
            assign x_in = (gc == 0) ? mix_l : mix_r;
            // One-pole shelf: y = x - x_prev/4 + y_prev/4
            assign y_wide = {{2{x_in[23]}}, x_in} - {{4{x_prev_reg[23]}}, x_prev_reg[23:2]}
                + {{4{y_prev_reg[23]}}, y_prev_reg[23:2]};
            assign y_filt = deemphasis_pin_on ? y_wide[23:0] : x_in;
            assign prod = $signed(y_filt) * $signed({1'b0, ramp_reg[gc]});
            assign ch_mute = (state_reg != PWR_PLAY)
                || (hw_mode && !pin.mute_pin_n)
                || (!hw_mode && mute_reg[2 + gc]);
            assign mute_req[gc] = ch_mute;
            assign rise_ramp = !hw_mode && mute_reg[1];
            assign fall_ramp = hw_mode || mute_reg[0];
            // Ramp steps once per sample, so its rate follows the sample rate
            always_ff @(posedge mclk) begin
                if (reset) begin
                    ramp_reg[gc] <= 9'h000;
                end else if (ch_mute && ramp_reg[gc] != 9'h000) begin
                    if (!fall_ramp) begin
                        ramp_reg[gc] <= 9'h000;
                    end else if (in_sample.valid) begin
                        ramp_reg[gc] <= ramp_reg[gc] - 9'h001;
                    end
                end else if (!ch_mute && ramp_reg[gc] != `GAIN_FULL) begin
                    if (!rise_ramp) begin
                        ramp_reg[gc] <= `GAIN_FULL;
                    end else if (in_sample.valid) begin
                        ramp_reg[gc] <= ramp_reg[gc] + 9'h001;
                    end
                end
            end
            // Filter history per channel
            always_ff @(posedge mclk) begin
                if (reset) begin
                    x_prev_reg <= 24'h000000;
                    y_prev_reg <= 24'h000000;
                end else if (in_sample.valid) begin
                    x_prev_reg <= x_in;
                    y_prev_reg <= y_wide[23:0];
                end
            end
        end
    endgenerate

    assign ramps_done = (ramp_reg[0] == 9'h000) && (ramp_reg[1] == 9'h000);

    // Output sample and strobe, one cycle after the input strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            out_sample <= '0;
        end else begin
            out_sample.valid <= in_sample.valid;
            if (in_sample.valid) begin
                // Both channels loaded together from the gain stage
                out_sample.left <= g_chan[0].prod[31:8];
                out_sample.right <= g_chan[1].prod[31:8];
            end
        end
    end

    // Zero run counter, counts only all-zero stereo samples
    assign both_zero = (in_sample.left == 24'h000000) && (in_sample.right == 24'h000000);
    assign zero_limit = (!hw_mode && zero_reg[0]) ? `ZERO_RUN_LONG : `ZERO_RUN_SHORT;
    assign zero_seen = (zero_cnt_reg >= zero_limit);
    always_ff @(posedge mclk) begin
        if (reset) begin
            zero_cnt_reg <= 12'h000;
        end else if (in_sample.valid) begin
            if (!both_zero) begin
                zero_cnt_reg <= 12'h000;
            end else if (!zero_seen) begin
                zero_cnt_reg <= zero_cnt_reg + 12'h001;
            end
        end
    end

    // Zero flag: run seen, or in pin mode muted-and-ramped or off
    always_ff @(posedge mclk) begin
        if (reset) begin
            zero_flag_out <= 1'b1;
        end else if (hw_mode) begin
            zero_flag_out <= zero_seen
                || (!pin.mute_pin_n && ramps_done)
                || (state_reg == PWR_OFF);
        end else begin
            zero_flag_out <= zero_seen;
        end
    end

endmodule : stereo_dac_digital_control

/* tb/audio_host_model.sv */
// Host audio source feeding stereo samples to the core.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps
module audio_host_model (
    // Clock
    input wire logic mclk,
    // Sample stream towards the core
    output dac_ctrl_pkg::sample_t smp
);
    import dac_ctrl_pkg::*;
    // Idle stream at start
    initial smp = '0;
    // One sample for one cycle; rate never changes, so no standby is needed
    task automatic send(input logic [23:0] l, input logic [23:0] r);
        @(negedge mclk);
        smp <= '{1'b1, l, r};
        @(negedge mclk);
        // Unqualified data shows the inverse of the last value
        smp <= '{1'b0, ~l, ~r};
    endtask : send
endmodule : audio_host_model

/* tb/dac_ctrl_checker.sv */
// Port checker for the stereo DAC control core.
// Assumes a bind onto the core and a synchronous active-high reset.
`timescale 1ns/1ps
module dac_ctrl_checker #(
    parameter logic [15:0] DEVICE_ID = 16'h5A3C, // Arbitrary identity value
    parameter logic [2:0] SILICON_REV = 3'h0 // Arbitrary revision value
) (
    // Clock, reset and register reads
    input wire logic mclk,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    // Pins, audio and status
    input wire dac_ctrl_pkg::pins_t pins,
    input wire dac_ctrl_pkg::sample_t in_sample,
    input wire dac_ctrl_pkg::sample_t out_sample,
    input wire logic zero_flag_out,
    input wire dac_ctrl_pkg::power_state_t power_state,
    input wire dac_ctrl_pkg::control_mode_t control_mode,
    input wire dac_ctrl_pkg::aif_cfg_t aif_cfg
);
    import dac_ctrl_pkg::*;
    // Single domain, checks paused in reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Fixed identity and revision reads
    a_id_read: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == DEVICE_ID) else $error("bad identity");
    a_rev_read: assert property (
        reg_rd && reg_addr == 8'h01 |=> reg_rdata == {13'h0000, SILICON_REV})
        else $error("bad revision");
    // Every sample comes out one cycle later
    a_sample_out: assert property (
        in_sample.valid |=> out_sample.valid) else $error("sample lost");
    // Nonzero sample drops the flag in register mode
    a_zero_clear: assert property (
        in_sample.valid && control_mode != CTRL_PINS && (in_sample.left != 24'h0
        || in_sample.right != 24'h0) |-> ##[1:2] !zero_flag_out) else $error("flag stuck");
    // Master clock loss forces off
    a_clock_stop_off: assert property (
        !pins.mclk_running [*6] |-> power_state == PWR_OFF) else $error("not off");
    // Floating select pin means pin control
    a_pin_mode: assert property (
        pins.cif_floating [*4] |-> control_mode == CTRL_PINS) else $error("bad mode");
    // Format pins 01 give 24-bit I2S
    a_pin_i2s: assert property (
        (control_mode == CTRL_PINS && !pins.format_pin_high && pins.format_pin_low) [*4]
        |-> aif_cfg.format_field == 2'b10 && aif_cfg.word_length_field == 2'b10)
        else $error("bad pin format");
    // Mute pin low in pin mode never leaves the device playing
    a_mute_no_play: assert property (
        (control_mode == CTRL_PINS && !pins.mute_pin_n) [*5] |-> power_state != PWR_PLAY)
        else $error("playing while muted");
endmodule : dac_ctrl_checker

/* tb/test_stereo_dac_digital_control.sv */
// Self-checking bench for the stereo DAC control core.
// Assumes core, checker and host model are compiled before it.
`timescale 1ns/1ps
`define CHECK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_stereo_dac_digital_control;
    import dac_ctrl_pkg::*;
    localparam logic [15:0] ID_VAL = 16'hC3A5; // Arbitrary identity value
    // Bench-driven inputs
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    pins_t pins = 8'hE0; // Clocks running, mute released, two-wire
    // Core outputs and captured read data
    logic [15:0] reg_rdata, rd;
    logic reg_rvalid, zero_flag_out, rv;
    logic [8:0] gain_l, gain_r;
    sample_t in_sample, out_sample;
    power_state_t power_state;
    control_mode_t control_mode;
    aif_cfg_t aif_cfg;
    int n_fail = 0;
    int check_count = 0;
    // Master clock, 100 ns period
    initial begin
        forever #50 mclk = ~mclk;
    end
    stereo_dac_digital_control #(.DEVICE_ID(ID_VAL), .SILICON_REV(3'h5))
        stereo_dac_digital_control_i (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .pins(pins), .in_sample(in_sample), .out_sample(out_sample),
        .zero_flag_out(zero_flag_out), .power_state(power_state), .control_mode(control_mode),
        .aif_cfg(aif_cfg), .left_gain_active(gain_l), .right_gain_active(gain_r));
    audio_host_model audio_host_model_i (.mclk(mclk), .smp(in_sample));
    // One register access; read data captured while valid
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        rv = reg_rvalid;
        rd = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask : acc
    // Read and compare
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        `CHECK(rv, 1'b1)
        `CHECK(rd, e)
    endtask : rchk
    // Bounded wait for a power state
    task automatic wait_state(input power_state_t s);
        for (int i = 0; i < 20 && power_state !== s; i++) @(negedge mclk);
        `CHECK(power_state, s)
    endtask : wait_state
    // Defaults, reserved bits, reserved divider, soft reset
    task automatic t_regs;
        logic [15:0] dflt [0:9] = '{ID_VAL, 16'h0005, 16'h0000, 16'h0012, 16'h0000,
            16'h0001, 16'h0190, 16'h0190, 16'h0000, 16'h0000};
        acc(1'b1, 8'h09, 16'hFFFF);
        for (int a = 0; a < 10; a++) rchk(8'(a), dflt[a]);
        acc(1'b1, 8'h02, 16'hFFFF);
        rchk(8'h02, 16'h0003);
        acc(1'b1, 8'h04, 16'h00EA);
        rchk(8'h04, 16'h00C2);
        acc(1'b1, 8'h07, 16'h0080);
        acc(1'b1, 8'h06, 16'h0240);
        `CHECK({gain_l, gain_r}, {9'h040, 9'h080})
        acc(1'b1, 8'h00, 16'h1234);
        rchk(8'h02, 16'h0000);
        rchk(8'h04, 16'h0000);
        `CHECK({gain_l, gain_r}, {9'h190, 9'h190})
        $display("test regs done");
    endtask : t_regs
    // All four output mux codes while playing
    task automatic t_mix;
        logic [23:0] el [0:3] = '{24'h000100, 24'h000100, 24'h000300, 24'h000200};
        logic [23:0] er [0:3] = '{24'h000300, 24'h000100, 24'h000300, 24'h000200};
        acc(1'b1, 8'h02, 16'h0003);
        wait_state(PWR_PLAY);
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, 8'h04, {8'h00, 2'(m), 6'h00});
            audio_host_model_i.send(24'h000100, 24'h000300);
            @(negedge mclk);
            `CHECK(out_sample.left, el[m])
            `CHECK(out_sample.right, er[m])
            `CHECK(zero_flag_out, 1'b0)
        end
        $display("test mix done");
    endtask : t_mix
    // Zero runs of both lengths, one short of and at the limit
    task automatic t_zero;
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, 8'h08, 16'(k));
            audio_host_model_i.send(24'h000001, 24'h000000);
            repeat ((1024 << k) - 1) audio_host_model_i.send(24'h0, 24'h0);
            repeat (3) @(negedge mclk);
            `CHECK(zero_flag_out, 1'b0)
            audio_host_model_i.send(24'h0, 24'h0);
            repeat (3) @(negedge mclk);
            `CHECK(zero_flag_out, 1'b1)
        end
        $display("test zero done");
    endtask : t_zero
    // Clock loss, then the pin-controlled power sequence
    task automatic t_power;
        pins.mclk_running = 1'b0;
        wait_state(PWR_OFF);
        rchk(8'h02, 16'h0003);
        pins.mclk_running = 1'b1;
        wait_state(PWR_PLAY);
        pins = 8'h45;
        wait_state(PWR_OFF);
        `CHECK(aif_cfg.format_field, 2'b10)
        pins.mclk_running = 1'b1;
        wait_state(PWR_STANDBY);
        pins.bclk_running = 1'b0;
        repeat (10) @(negedge mclk);
        `CHECK(power_state, PWR_STANDBY)
        pins.mute_pin_n = 1'b1;
        pins.bclk_running = 1'b1;
        wait_state(PWR_PLAY);
        pins.mute_pin_n = 1'b0;
        repeat (260) audio_host_model_i.send(24'h000100, 24'h000100);
        `CHECK(out_sample.left, 24'h000000)
        wait_state(PWR_STANDBY);
        `CHECK(zero_flag_out, 1'b1)
        pins.mute_pin_n = 1'b1;
        wait_state(PWR_PLAY);
        audio_host_model_i.send(24'h000100, 24'h000100);
        @(negedge mclk);
        `CHECK(out_sample.left, 24'h000100)
        `CHECK(zero_flag_out, 1'b0)
        pins.mclk_running = 1'b0;
        wait_state(PWR_OFF);
        // Flag is registered one cycle behind the state
        @(negedge mclk);
        `CHECK(zero_flag_out, 1'b1)
        $display("test power done");
    endtask : t_power
    // Counts, verdict and stop
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        t_regs();
        t_mix();
        t_zero();
        t_power();
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        #5ms;
        n_fail++;
        end_sim();
    end
endmodule : test_stereo_dac_digital_control
bind stereo_dac_digital_control dac_ctrl_checker #(.DEVICE_ID(DEVICE_ID),
    .SILICON_REV(SILICON_REV)) dac_ctrl_checker_i (.mclk(mclk), .reset(reset), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .pins(pins), .in_sample(in_sample),
    .out_sample(out_sample), .zero_flag_out(zero_flag_out), .power_state(power_state),
    .control_mode(control_mode), .aif_cfg(aif_cfg));
